// *** design/odl_fifo.sv ***
// Word FIFO with registered read data, parameter width and depth.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module odl_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   odl_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic [WIDTH-1:0] dout_q, dout_d;
   logic ovalid_q, ovalid_d;
   logic push, pop, take;

   assign f.in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign f.out_valid = ovalid_q;
   assign f.out_data = dout_q;
   assign push = f.in_valid && f.in_ready;
   // Move one word into the output register when it is free
   assign take = (cnt_q != '0) && (!ovalid_q || f.out_ready);
   assign pop = take;

   always_comb begin
      wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
      rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      dout_d = take ? mem_q[rd_q] : dout_q;
      if (take) begin
         ovalid_d = 1'b1;
      end else if (f.out_ready) begin
         ovalid_d = 1'b0;
      end else begin
         ovalid_d = ovalid_q;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_q] <= f.in_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         dout_q <= '0;
         ovalid_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         dout_q <= dout_d;
         ovalid_q <= ovalid_d;
      end
   end
endmodule : odl_fifo
`default_nettype wire

// *** design/odl_fifo_if.sv ***
// Interface: valid/ready word channel between loader and its word FIFO.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface odl_fifo_if #(parameter int WIDTH = 16);
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WIDTH-1:0] out_data;
   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : odl_fifo_if
`default_nettype wire

// *** design/odl_loader.sv ***
// Top: serial loader, input latches and converter latches for eight channels.
// Assumes serial pins, load-all and clear arrive asynchronously to I_CLK.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) With frame sync low, capture data on each serial clock falling edge.
// (R2) After sixteen bits stop shifting until frame sync falls again.
// (R3) Shift received bits out on the rising clock edge after each capture.
// (R4) Accept word only when its address bit equals the strap pin.
// (R5) Low three word bits select channel zero to seven.
// (R6) Load-all low copies every input latch to its converter latch.
// (R7) Clear low forces all converter latches to zero.
// (R8) Clear leaves input latches unchanged.
// (R9) Top two code bits drive three segment switches, low ten drive ladder.
// (R10) Word order: code MSB first, address bit, then three select bits.
// (R11) Accepted code written to input latch on sixteenth falling edge; code goes via the word FIFO, two I_CLK cycles after the shift.
// (R12) Mismatched words still pass out on serial data output.
// (R13) Load-all and clear act without serial clock; clear wins.
module odl_loader
   import odl_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic i_frame_sync_n,
   input wire logic i_serial_clock_in,
   input wire logic i_serial_data_in,
   input wire logic i_device_address_strap,
   input wire logic i_load_all_n,
   input wire logic i_clear_all_n,
   output logic o_serial_data_out,
   output logic [NUM_CHANNELS*CODE_BITS-1:0] o_converter_code,
   output logic [NUM_CHANNELS*SEG_SWITCHES-1:0] o_segment_switch,
   output logic [NUM_CHANNELS*LADDER_BITS-1:0] o_ladder_switch,
   output logic o_word_accepted,
   output logic o_fifo_overflow
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: three stages, change taken when stages 2 and 3 agree
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_q, s2_q, s3_q, clean_q, clean_d;
   logic [NSYNC-1:0] s1_d, s2_d, s3_d;
   assign pin_raw = {i_frame_sync_n, i_serial_clock_in, i_serial_data_in,
                     i_device_address_strap, i_load_all_n, i_clear_all_n};

   always_comb begin
      s1_d = pin_raw;
      s2_d = s1_q;
      s3_d = s2_q;
      clean_d = clean_q;
      for (int i = 0; i < NSYNC; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            clean_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         // Serial clock rests low, every other pin high
         s1_q <= 6'h2f;
         s2_q <= 6'h2f;
         s3_q <= 6'h2f;
         clean_q <= 6'h2f;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         clean_q <= clean_d;
      end
   end

   logic fs_n, sclk, sdat, strap, ldall_n, clr_n;
   logic fs_prev_q, fs_prev_d, sclk_prev_q, sclk_prev_d;
   assign {fs_n, sclk, sdat, strap, ldall_n, clr_n} = clean_q;

   // Levels one cycle back, for edge detection
   always_comb begin
      fs_prev_d = fs_n;
      sclk_prev_d = sclk;
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         fs_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         fs_prev_q <= fs_prev_d;
         sclk_prev_q <= sclk_prev_d;
      end
   end

   logic fs_fall, sclk_fall, sclk_rise;
   assign fs_fall = fs_prev_q && !fs_n;
   assign sclk_fall = sclk_prev_q && !sclk;
   assign sclk_rise = !sclk_prev_q && sclk;

   ////////////////////////////////////////////////////////////////////////////
   // Serial frame state machine and shift register
   odl_state_t state_q, state_d;
   logic [WORD_BITS-1:0] shreg_q, shreg_d;
   logic [COUNT_BITS-1:0] count_q, count_d;
   logic sdo_q, sdo_d;
   logic out_pend_q, out_pend_d;
   logic word_done;

   always_comb begin
      state_d = state_q;
      shreg_d = shreg_q;
      count_d = count_q;
      sdo_d = sdo_q;
      out_pend_d = out_pend_q;
      word_done = 1'b0;
      // Daisy-chain output follows the capture on the next rising edge
      if (sclk_rise && out_pend_q) begin
         sdo_d = shreg_q[WORD_BITS-1]; // R3 R12
         out_pend_d = 1'b0;
      end
      case (state_q)
         ODL_IDLE: begin
            if (fs_fall) begin
               state_d = ODL_SHIFT;
               count_d = '0;
            end
         end
         ODL_SHIFT: begin
            if (fs_n) begin
               state_d = ODL_IDLE;
            end else if (sclk_fall) begin
               // Bits enter LSB end, so the first bit ends in bit 15
               shreg_d = {shreg_q[WORD_BITS-2:0], sdat}; // R1 R10
               out_pend_d = 1'b1;
               count_d = count_q + 5'h01;
               if (count_q + 5'h01 == COUNT_FULL) begin
                  state_d = ODL_DONE; // R2
                  word_done = 1'b1; // R11
               end
            end
         end
         ODL_DONE: begin
            if (fs_fall) begin // R2
               state_d = ODL_SHIFT;
               count_d = '0;
            end
         end
         default: begin
            state_d = ODL_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state_q <= ODL_IDLE;
         shreg_q <= '0;
         count_q <= '0;
         sdo_q <= 1'b0;
         out_pend_q <= 1'b0;
      end else begin
         state_q <= state_d;
         shreg_q <= shreg_d;
         count_q <= count_d;
         sdo_q <= sdo_d;
         out_pend_q <= out_pend_d;
      end
   end

   assign o_serial_data_out = sdo_q;

   ////////////////////////////////////////////////////////////////////////////
   // Word FIFO between the shifter and the input latches
   logic [WORD_BITS-1:0] new_word;
   assign new_word = shreg_d;
   odl_fifo_if #(.WIDTH(WORD_BITS)) wf ();
   assign wf.in_valid = word_done;
   assign wf.in_data = new_word;
   assign wf.out_ready = 1'b1;
   odl_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .f(wf.fifo)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Input latches and converter latches
   logic [CODE_BITS-1:0] in_latch_q [NUM_CHANNELS];
   logic [CODE_BITS-1:0] in_latch_d [NUM_CHANNELS];
   logic [CODE_BITS-1:0] conv_q [NUM_CHANNELS];
   logic [CODE_BITS-1:0] conv_d [NUM_CHANNELS];
   logic accept_d, accept_q, ovf_d, ovf_q;
   logic [SEL_BITS-1:0] sel;
   logic [NUM_CHANNELS-1:0] sel_hot;
   logic addr_ok;

   // Field extraction from a received word
   function automatic logic [CODE_BITS-1:0] word_code(input logic [WORD_BITS-1:0] w);
      word_code = w[CODE_MSB:CODE_LSB];
   endfunction : word_code

   function automatic logic [SEL_BITS-1:0] word_sel(input logic [WORD_BITS-1:0] w);
      word_sel = w[SEL_MSB:SEL_LSB];
   endfunction : word_sel

   function automatic logic word_addr(input logic [WORD_BITS-1:0] w);
      word_addr = w[ADDR_BIT];
   endfunction : word_addr

   function automatic logic [NUM_CHANNELS-1:0] chan_onehot(input logic [SEL_BITS-1:0] s);
      chan_onehot = '0;
      chan_onehot[s] = 1'b1;
   endfunction : chan_onehot

   assign sel = word_sel(wf.out_data); // R5
   assign sel_hot = chan_onehot(sel); // R5
   assign addr_ok = (word_addr(wf.out_data) == strap); // R4

   always_comb begin
      accept_d = 1'b0;
      ovf_d = ovf_q || (word_done && !wf.in_ready);
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         in_latch_d[c] = in_latch_q[c];
         conv_d[c] = conv_q[c];
         if (wf.out_valid && addr_ok && sel_hot[c]) begin
            in_latch_d[c] = word_code(wf.out_data); // R4 R5 R11
         end
         if (!clr_n) begin
            conv_d[c] = CODE_RESET; // R7 R8 R13
         end else if (!ldall_n) begin
            conv_d[c] = in_latch_q[c]; // R6 R13
         end
      end
      if (wf.out_valid && addr_ok) begin
         accept_d = 1'b1;
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         for (int c = 0; c < NUM_CHANNELS; c++) begin
            in_latch_q[c] <= CODE_RESET;
            conv_q[c] <= CODE_RESET;
         end
         accept_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         for (int c = 0; c < NUM_CHANNELS; c++) begin
            in_latch_q[c] <= in_latch_d[c];
            conv_q[c] <= conv_d[c];
         end
         accept_q <= accept_d;
         ovf_q <= ovf_d;
      end
   end

   assign o_word_accepted = accept_q;
   assign o_fifo_overflow = ovf_q;

   ////////////////////////////////////////////////////////////////////////////
   // Segmented decode of each converter code
   function automatic logic [SEG_SWITCHES-1:0] seg_decode(input logic [SEG_BITS-1:0] top);
      case (top)
         2'h0: seg_decode = 3'h0;
         2'h1: seg_decode = 3'h1;
         2'h2: seg_decode = 3'h3;
         default: seg_decode = 3'h7;
      endcase
   endfunction : seg_decode

   logic [NUM_CHANNELS*SEG_SWITCHES-1:0] seg_d, seg_q;
   always_comb begin
      seg_d = '0;
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         seg_d[c*SEG_SWITCHES +: SEG_SWITCHES] =
            seg_decode(conv_d[c][CODE_BITS-1 -: SEG_BITS]); // R9
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         seg_q <= '0;
      end else begin
         seg_q <= seg_d;
      end
   end

   assign o_segment_switch = seg_q;
   always_comb begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         o_converter_code[c*CODE_BITS +: CODE_BITS] = conv_q[c];
         o_ladder_switch[c*LADDER_BITS +: LADDER_BITS] = conv_q[c][LADDER_BITS-1:0]; // R9
      end
   end

endmodule : odl_loader
`default_nettype wire

// *** design/odl_pkg.sv ***
// Package: constants for the octal converter serial loader.
// Assumes a single system clock; serial pins are sampled asynchronously.
package odl_pkg;
   localparam int WORD_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int NUM_CHANNELS = 8;
   localparam int SEL_BITS = 3;
   // Field positions in the received word
   localparam int CODE_MSB = 15;
   localparam int CODE_LSB = 4;
   localparam int ADDR_BIT = 3;
   localparam int SEL_MSB = 2;
   localparam int SEL_LSB = 0;
   // Segmented decode split
   localparam int SEG_BITS = 2;
   localparam int LADDER_BITS = 10;
   localparam int SEG_SWITCHES = 3;
   localparam int COUNT_BITS = 5;
   localparam logic [COUNT_BITS-1:0] COUNT_FULL = 5'h10;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
   localparam int FIFO_DEPTH = 16;
   localparam int SYNC_STAGES = 3;
   typedef enum logic [1:0] {
      ODL_IDLE,
      ODL_SHIFT,
      ODL_DONE
   } odl_state_t;
endpackage : odl_pkg

// *** sim/odl_host_model.sv ***
// Host model: sends frames on the serial pins, records the daisy output.
// Assumes the bench clock; serial clock rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module odl_host_model (
   input wire logic i_clk,
   input wire logic i_sdo,
   output logic o_fs_n,
   output logic o_sclk,
   output logic o_sdi,
   output logic [15:0] o_seen
);
   initial begin
      o_fs_n = 1'b1;
      o_sclk = 1'b0;
      o_sdi = 1'b0;
      o_seen = 16'h0000;
   end
   task automatic frame(input logic [15:0] w, input int extra);
      logic [31:0] bits;
      bits = {w, 16'($urandom)};
      @(negedge i_clk) o_fs_n <= 1'b0;
      repeat (4) @(negedge i_clk);
      for (int i = 0; i < 16 + extra; i++) begin
         o_sclk <= 1'b1;
         o_sdi <= bits[31-i];
         repeat (4) @(negedge i_clk);
         o_sclk <= 1'b0;
         repeat (4) @(negedge i_clk);
         if (i < 16) o_seen[15-i] = i_sdo;
      end
      o_fs_n <= 1'b1;
      o_sdi <= ~o_sdi;
      repeat (8) @(negedge i_clk);
   endtask : frame
endmodule : odl_host_model
`default_nettype wire

// *** sim/odl_loader_props.sv ***
// Checker: port-level properties of the serial loader.
// Assumes pin levels reach the latches through a short synchroniser.
`timescale 1ns/1ps
`default_nettype none
module odl_loader_props
   import odl_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic i_serial_clock_in,
   input wire logic i_load_all_n,
   input wire logic i_clear_all_n,
   input wire logic o_serial_data_out,
   input wire logic [NUM_CHANNELS*CODE_BITS-1:0] o_converter_code,
   input wire logic [NUM_CHANNELS*SEG_SWITCHES-1:0] o_segment_switch,
   input wire logic [NUM_CHANNELS*LADDER_BITS-1:0] o_ladder_switch,
   input wire logic o_word_accepted
);
   logic [NUM_CHANNELS*SEG_SWITCHES-1:0] seg_x;
   logic [NUM_CHANNELS*LADDER_BITS-1:0] lad_x;
   logic [3:0] sclk_low_q;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         seg_x[3*c +: 3] = {&o_converter_code[12*c+10 +: 2], o_converter_code[12*c+11],
            |o_converter_code[12*c+10 +: 2]};
         lad_x[10*c +: 10] = o_converter_code[12*c +: 10];
      end
   end
   // Cycles the serial clock pin has stayed low, saturating
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sclk_low_q <= 4'h0;
      end else if (i_serial_clock_in) begin
         sclk_low_q <= 4'h0;
      end else if (sclk_low_q != 4'hf) begin
         sclk_low_q <= sclk_low_q + 4'h1;
      end
   end
   AST_SEG: assert property (o_segment_switch == seg_x)
      else $error("segment switches off code");
   AST_LADDER: assert property (o_ladder_switch == lad_x)
      else $error("ladder switches off code");
   AST_CLEAR: assert property (!i_clear_all_n [*7] |-> o_converter_code == '0)
      else $error("clear did not zero latches");
   AST_CLEAR_WINS: assert property ((!i_clear_all_n && !i_load_all_n) [*7] |->
      o_converter_code == '0) else $error("load beat clear");
   AST_HOLD: assert property ((i_load_all_n && i_clear_all_n) [*7] |->
      $stable(o_converter_code)) else $error("latches moved without load");
   AST_ACC_PULSE: assert property (o_word_accepted |=> !o_word_accepted)
      else $error("accept pulse too long");
   AST_ACC_QUIET: assert property ((!i_serial_clock_in && sclk_low_q >= 4'hb) |->
      !o_word_accepted) else $error("accept without falling edge");
   AST_SDO_HOLD: assert property (!i_serial_clock_in [*8] |-> $stable(o_serial_data_out))
      else $error("daisy output moved without rise");
endmodule : odl_loader_props
bind odl_loader odl_loader_props #(.FIFO_WORDS(FIFO_WORDS)) u_props (.I_CLK, .I_SYS_RST,
   .i_serial_clock_in, .i_load_all_n, .i_clear_all_n, .o_serial_data_out, .o_converter_code,
   .o_segment_switch, .o_ladder_switch, .o_word_accepted);
`default_nettype wire

// *** sim/testbench.sv ***
// Testbench: host model frames into the loader, bench model of the latches.
// Assumes pin-to-latch latency well under the waits used here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b0;
   logic ld_n = 1'b1;
   logic clr_n = 1'b1;
   logic fs_n, sclk, sdi, sdo, acc, ovf;
   logic [95:0] code;
   logic [15:0] seen;
   logic [15:0] prev = '0;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   int nacc = 0;
   int exp_acc = 0;
   int in_l[8] = '{default: 0};
   int conv[8] = '{default: 0};
   ////////////////////////////////////////////////////////////////////////////
   initial forever #5 clk = ~clk;
   odl_loader DUT (.I_CLK(clk), .I_SYS_RST(rst), .i_frame_sync_n(fs_n),
      .i_serial_clock_in(sclk), .i_serial_data_in(sdi), .i_device_address_strap(strap),
      .i_load_all_n(ld_n), .i_clear_all_n(clr_n), .o_serial_data_out(sdo),
      .o_converter_code(code), .o_segment_switch(), .o_ladder_switch(),
      .o_word_accepted(acc), .o_fifo_overflow(ovf));
   odl_host_model u_host (.i_clk(clk), .i_sdo(sdo), .o_fs_n(fs_n), .o_sclk(sclk),
      .o_sdi(sdi), .o_seen(seen));
   always @(posedge clk) begin
      cyc++;
      if (acc === 1'b1) nacc++;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task automatic compare(input string what, input logic [95:0] exp, input logic [95:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : compare
   task automatic compare_word(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : compare_word
   task automatic compare_count(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask : compare_count
   task automatic compare_flag(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : compare_flag
   function automatic logic [95:0] conv_vec();
      logic [95:0] v;
      for (int c = 0; c < 8; c++) v[12*c +: 12] = conv[c][11:0];
      return v;
   endfunction : conv_vec
   task automatic send(input logic [11:0] cd, input logic a, input logic [2:0] ch, input int ex);
      logic [15:0] w;
      int n;
      w = {cd, a, ch};
      // A negative extra count cuts the frame short by raising frame sync
      n = (ex < 0) ? 16 + ex : 16;
      u_host.frame(w, ex);
      if (a === strap && ex >= 0) begin
         in_l[ch] = cd;
         exp_acc++;
      end
      repeat (4) @(negedge clk);
      compare_word("daisy", prev >> (16 - n), seen >> (16 - n));
      compare_count("accepts", exp_acc, nacc);
      prev = (prev << n) | (w >> (16 - n));
   endtask : send
   task automatic levels(input logic l, input logic c);
      @(negedge clk);
      ld_n = l;
      clr_n = c;
      repeat (10) @(negedge clk);
      for (int k = 0; k < 8; k++) begin
         if (!c) conv[k] = 0;
         else if (!l) conv[k] = in_l[k];
      end
      compare("converter", conv_vec(), code);
   endtask : levels
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(92));
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      for (int r = 0; r < 3; r++) begin
         strap = r[0];
         for (int ch = 0; ch < 8; ch++) begin
            send(12'($urandom), strap ^ (ch == 5), 3'(ch), ch % 3 * 2);
         end
         send(12'hfff, strap, 3'(r), 0);
         send(12'($urandom), strap, 3'(r), -4 - r * 3);
         levels(1'b0, 1'b1);
         levels(1'b1, 1'b1);
      end
      levels(1'b1, 1'b0);
      levels(1'b0, 1'b0);
      levels(1'b0, 1'b1);
      levels(1'b1, 1'b1);
      compare_flag("overflow", 1'b0, ovf);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
